// ### verilog/lsbp_map.vh
// Command codes, pin encodings and timing counts for the burst stop / precharge controller
`ifndef LSBP_MAP_VH
`define LSBP_MAP_VH

// User command opcodes
`define LSBP_OP_ACT      3'h0
`define LSBP_OP_READ     3'h1
`define LSBP_OP_WRITE    3'h2
`define LSBP_OP_BST      3'h3
`define LSBP_OP_PRE      3'h4
`define LSBP_OP_PREA     3'h5

// Rising-edge command bits CA3..CA0
`define LSBP_CA_ACT      4'h2
`define LSBP_CA_READ     4'h5
`define LSBP_CA_WRITE    4'h1
`define LSBP_CA_BST      4'h3
`define LSBP_CA_PRE      4'hb
`define LSBP_CA_NOP      4'h7

// Field positions on the command/address bus
`define LSBP_CA_AB_BIT   4
`define LSBP_CA_BA_LO    7
`define LSBP_CA_AP_BIT   0

// Mode settings
`define LSBP_BL          8
`define LSBP_RL          3
`define LSBP_WL          1

// Times in ns; device clock is the controller clock divided by two
`define LSBP_TCK_NS      50
`define LSBP_TRAS_NS     42
`define LSBP_TRPPB_NS    18
`define LSBP_TRPAB_NS    21
`define LSBP_TRTP_NS     8
`define LSBP_TWR_NS      15
`define LSBP_TWTR_NS     8
`define LSBP_TDQSCK_NS   6

// Least times rounded up to whole device clocks, never below one
`define LSBP_RU(t)       ((((t) + `LSBP_TCK_NS - 1) / `LSBP_TCK_NS) < 1 ? 1 : \
                          (((t) + `LSBP_TCK_NS - 1) / `LSBP_TCK_NS))

// Data path
`define LSBP_DQ_W        16
`define LSBP_DM_W        2
`define LSBP_FIFO_DEPTH  8

`endif

// ### verilog/lsbp_ctrl.v
// Host-side controller issuing burst stop, precharge and auto-precharge accesses
// How it works
// - Burst stop sent as CS low, CA0 CA1 high, CA2 CA3 low.
// - Burst stop only during a live burst, at most BL/2-1 cycles after it.
// - Read/write turnaround uses the effective length after a stop.
// - Stop only an even number of cycles after the access.
// - One stop per access; next needs a new read or write.
// - Mask pins driven with the same timing as the lane data.
// - Precharge sent as CS low, CA0 CA1 high, CA2 low, CA3 high.
// - Reopen waits tRPab after precharge all, tRPpb after single.
// - Precharge after read no sooner than BL/2, and after tRAS.
// - No precharge before tRAS from that bank's activate.
// - No activate before the precharge time has elapsed.
// - Read-to-precharge tRTP starts BL/2-2 after the read.
// - Write to precharge waits WL+BL/2+1+RU(tWR/tCK).
// - Never stop an access that carries auto-precharge.
`timescale 1ns/1ps
`include "lsbp_map.vh"

module lsbp_ctrl (
    input  wire                         i_mclk,
    input  wire                         i_resetn,
    input  wire                         i_cmd_valid,
    input  wire [2:0]                   i_cmd_op,
    input  wire [2:0]                   i_cmd_bank,
    input  wire [12:0]                  i_cmd_addr,
    input  wire                         i_cmd_ap,
    input  wire                         i_wdata_valid,
    input  wire [2*`LSBP_DQ_W-1:0]      i_wdata,
    input  wire [2*`LSBP_DM_W-1:0]      i_wmask,
    output wire                         o_wdata_ready,
    output reg                          o_cmd_ack,
    output reg                          o_cmd_refused,
    output reg  [7:0]                   o_bank_open,
    output reg                          o_ck,
    output reg                          o_cs_n,
    output reg  [9:0]                   o_ca,
    output reg  [`LSBP_DQ_W-1:0]        o_dq,
    output reg                          o_dq_oe,
    output reg  [`LSBP_DM_W-1:0]        o_dm,
    output reg                          o_dqs,
    output reg                          o_dqs_oe
);

    localparam [5:0] HALF    = `LSBP_BL / 2;
    localparam [5:0] RAS_CK  = `LSBP_RU(`LSBP_TRAS_NS);
    localparam [5:0] RPPB_CK = `LSBP_RU(`LSBP_TRPPB_NS);
    localparam [5:0] RPAB_CK = `LSBP_RU(`LSBP_TRPAB_NS);
    localparam [5:0] RTP_CK  = `LSBP_RU(`LSBP_TRTP_NS);
    localparam [5:0] WR_CK   = `LSBP_RU(`LSBP_TWR_NS);
    localparam [5:0] WTR_CK  = `LSBP_RU(`LSBP_TWTR_NS);
    localparam [5:0] DQSCK   = `LSBP_RU(`LSBP_TDQSCK_NS);
    localparam [5:0] RL      = `LSBP_RL;
    localparam [5:0] WL      = `LSBP_WL;
    localparam [5:0] RTP2    = (RTP_CK > 6'h02) ? RTP_CK : 6'h02;
    localparam [5:0] RD_PRE  = HALF + RTP2 - 6'h02;
    localparam [5:0] WR_PRE  = WL + HALF + 6'h01 + WR_CK;
    localparam [5:0] RD_WR   = RL + DQSCK + HALF + 6'h01 - WL;
    localparam [5:0] WR_RD   = WL + 6'h01 + HALF + WTR_CK;
    localparam [5:0] BST_RPRE = (RTP2 > 6'h03) ? (RTP2 - 6'h02) : 6'h01;
    localparam [5:0] BST_WPRE = WL + WR_CK + 6'h01;
    localparam [5:0] BST_RWR  = RL + DQSCK + 6'h01 - WL;
    localparam [5:0] BST_WRD  = WL + 6'h01 + WTR_CK;
    localparam [3:0] FIFO_CW  = 4'h4;

    // Reset release through two flops
    reg         rst_meta_n, rst_n;
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Write data FIFO, two beats per word
    wire                               fifo_out_valid;
    wire [2*(`LSBP_DQ_W+`LSBP_DM_W)-1:0] fifo_out_data;
    wire [FIFO_CW-1:0]                 fifo_count;
    wire                               fifo_pop;
    lsbp_fifo #(
        .W (2*(`LSBP_DQ_W+`LSBP_DM_W)),
        .D (`LSBP_FIFO_DEPTH),
        .CW(FIFO_CW)
    ) u_fifo (
        .i_clk      (i_mclk),
        .i_rst_n    (rst_n),
        .i_in_valid (i_wdata_valid),
        .i_in_data  ({i_wmask[2*`LSBP_DM_W-1:`LSBP_DM_W], i_wdata[2*`LSBP_DQ_W-1:`LSBP_DQ_W],
                      i_wmask[`LSBP_DM_W-1:0], i_wdata[`LSBP_DQ_W-1:0]}),
        .o_in_ready (o_wdata_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data (fifo_out_data),
        .i_out_ready(fifo_pop),
        .o_count    (fifo_count)
    );

    // Per-bank timers and burst tracking
    reg  [5:0]  ras_wait [0:7], pre_wait [0:7], act_wait [0:7];
    reg         ph, live, live_wr, live_ap, bst_done, fall_ap;
    reg  [5:0]  rd_wait, wr_wait, age, wlat, wleft, wdrv, fall_ca;
    reg  [2:0]  live_bank;
    reg  [`LSBP_DQ_W+`LSBP_DM_W-1:0] fall_hold;
    integer     b;

    // Command legality for the request on offer
    reg         legal, refuse, all_pre_ok;
    always @* begin
        legal      = 1'b0;
        refuse     = 1'b0;
        all_pre_ok = 1'b1;
        for (b = 0; b < 8; b = b + 1) begin
            if (ras_wait[b] != 6'h00 || pre_wait[b] != 6'h00) begin
                all_pre_ok = 1'b0;
            end
        end
        case (i_cmd_op)
            `LSBP_OP_ACT: begin
                legal = !o_bank_open[i_cmd_bank] && act_wait[i_cmd_bank] == 6'h00;
            end
            `LSBP_OP_READ: begin
                legal = o_bank_open[i_cmd_bank] && rd_wait == 6'h00 && wleft == 6'h00;
            end
            `LSBP_OP_WRITE: begin
                legal = o_bank_open[i_cmd_bank] && wr_wait == 6'h00 && wleft == 6'h00 &&
                        fifo_count >= HALF[FIFO_CW-1:0];
            end
            `LSBP_OP_BST: begin
                // Stop only inside the burst, on an even cycle, once, never on auto-precharge
                refuse = !live || bst_done || live_ap || age[0] ||
                         age > HALF - 6'h01;
                legal  = !refuse;
            end
            `LSBP_OP_PRE: begin
                legal = ras_wait[i_cmd_bank] == 6'h00 && pre_wait[i_cmd_bank] == 6'h00;
            end
            `LSBP_OP_PREA: legal = all_pre_ok;
            default: refuse = 1'b1;
        endcase
    end

    wire take = rst_n && !ph && i_cmd_valid && legal;
    wire drop = rst_n && !ph && i_cmd_valid && refuse;

    // Command engine: decide on the rising half, send fall word on the other
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph            <= 1'b0;
            o_ck          <= 1'b0;
            o_cs_n        <= 1'b1;
            o_ca          <= 10'h000;
            o_cmd_ack     <= 1'b0;
            o_cmd_refused <= 1'b0;
            o_bank_open   <= 8'h00;
            rd_wait       <= 6'h00;
            wr_wait       <= 6'h00;
            age           <= 6'h00;
            live          <= 1'b0;
            live_wr       <= 1'b0;
            live_ap       <= 1'b0;
            bst_done      <= 1'b0;
            live_bank     <= 3'h0;
            fall_ca       <= 6'h00;
            fall_ap       <= 1'b0;
            for (b = 0; b < 8; b = b + 1) begin
                ras_wait[b] <= 6'h00;
                pre_wait[b] <= 6'h00;
                act_wait[b] <= 6'h00;
            end
        end else begin
            ph            <= !ph;
            o_ck          <= !ph;
            o_cmd_ack     <= take;
            o_cmd_refused <= drop;
            if (ph) begin
                // Falling half: address or auto-precharge bit
                o_ca <= {fall_ca[5:0], 3'h0, fall_ap};
            end else begin
                // Age every timer once per device clock
                for (b = 0; b < 8; b = b + 1) begin
                    if (ras_wait[b] != 6'h00) ras_wait[b] <= ras_wait[b] - 6'h01;
                    if (pre_wait[b] != 6'h00) pre_wait[b] <= pre_wait[b] - 6'h01;
                    if (act_wait[b] != 6'h00) act_wait[b] <= act_wait[b] - 6'h01;
                end
                if (rd_wait != 6'h00) rd_wait <= rd_wait - 6'h01;
                if (wr_wait != 6'h00) wr_wait <= wr_wait - 6'h01;
                if (live) begin
                    age <= age + 6'h01;
                    if (age >= HALF - 6'h01) live <= 1'b0;
                end
                o_cs_n  <= !take;
                o_ca    <= {6'h00, `LSBP_CA_NOP};
                fall_ca <= 6'h00;
                fall_ap <= 1'b0;
                if (take) begin
                    case (i_cmd_op)
                        `LSBP_OP_ACT: begin
                            o_ca <= {i_cmd_bank, i_cmd_addr[2:0], `LSBP_CA_ACT};
                            fall_ca <= i_cmd_addr[8:3];
                            o_bank_open[i_cmd_bank] <= 1'b1;
                            ras_wait[i_cmd_bank] <= RAS_CK;
                        end
                        `LSBP_OP_READ, `LSBP_OP_WRITE: begin
                            o_ca <= {i_cmd_bank, 1'b0, i_cmd_addr[1:0],
                                     (i_cmd_op == `LSBP_OP_READ) ? `LSBP_CA_READ : `LSBP_CA_WRITE};
                            fall_ca <= i_cmd_addr[7:2];
                            fall_ap <= i_cmd_ap;
                            live      <= 1'b1;
                            live_wr   <= (i_cmd_op == `LSBP_OP_WRITE);
                            live_ap   <= i_cmd_ap;
                            bst_done  <= 1'b0;
                            live_bank <= i_cmd_bank;
                            age       <= 6'h01;
                            if (i_cmd_op == `LSBP_OP_READ) begin
                                wr_wait <= RD_WR;
                                if (pre_wait[i_cmd_bank] < RD_PRE)
                                    pre_wait[i_cmd_bank] <= RD_PRE;
                                if (i_cmd_ap)
                                    act_wait[i_cmd_bank] <= RD_PRE + RPPB_CK;
                            end else begin
                                rd_wait <= WR_RD;
                                if (pre_wait[i_cmd_bank] < WR_PRE)
                                    pre_wait[i_cmd_bank] <= WR_PRE;
                                if (i_cmd_ap)
                                    act_wait[i_cmd_bank] <= WR_PRE + RPPB_CK;
                            end
                            // Auto-precharge closes the bank; plain access keeps it open
                            if (i_cmd_ap)
                                o_bank_open[i_cmd_bank] <= 1'b0;
                        end
                        `LSBP_OP_BST: begin
                            o_ca     <= {6'h00, `LSBP_CA_BST};
                            live     <= 1'b0;
                            bst_done <= 1'b1;
                            // Spacing recomputed from the effective length 2 x age
                            if (live_wr) begin
                                rd_wait <= BST_WRD;
                                pre_wait[live_bank] <= BST_WPRE;
                            end else begin
                                wr_wait <= BST_RWR;
                                pre_wait[live_bank] <= BST_RPRE;
                            end
                        end
                        `LSBP_OP_PRE: begin
                            o_ca <= {i_cmd_bank, 2'h0, 1'b0, `LSBP_CA_PRE};
                            o_bank_open[i_cmd_bank] <= 1'b0;
                            act_wait[i_cmd_bank] <= RPPB_CK;
                        end
                        `LSBP_OP_PREA: begin
                            o_ca <= {3'h0, 2'h0, 1'b1, `LSBP_CA_PRE};
                            o_bank_open <= 8'h00;
                            for (b = 0; b < 8; b = b + 1)
                                act_wait[b] <= RPAB_CK;
                        end
                        default: o_ca <= {6'h00, `LSBP_CA_NOP};
                    endcase
                end
            end
        end
    end

    // Write data: WL clocks after the write, one FIFO word per device clock
    wire wr_start = take && (i_cmd_op == `LSBP_OP_WRITE);
    wire wr_stop  = take && (i_cmd_op == `LSBP_OP_BST) && live_wr;
    assign fifo_pop = rst_n && !ph && wleft != 6'h00 && wlat == 6'h00 && fifo_out_valid;

    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            wlat      <= 6'h00;
            wleft     <= 6'h00;
            wdrv      <= 6'h00;
            fall_hold <= {(`LSBP_DQ_W+`LSBP_DM_W){1'b0}};
            o_dq      <= {`LSBP_DQ_W{1'b0}};
            o_dm      <= {`LSBP_DM_W{1'b0}};
            o_dq_oe   <= 1'b0;
            o_dqs     <= 1'b0;
            o_dqs_oe  <= 1'b0;
        end else if (ph) begin
            // Falling beat: data and mask move together
            o_dq  <= fall_hold[`LSBP_DQ_W-1:0];
            o_dm  <= fall_hold[`LSBP_DQ_W+`LSBP_DM_W-1:`LSBP_DQ_W];
            o_dqs <= 1'b0;
        end else begin
            if (wlat != 6'h00) wlat <= wlat - 6'h01;
            if (wr_start) begin
                wlat  <= WL - 6'h01;                            // First word WL clocks on
                wleft <= HALF;
                wdrv  <= HALF;
            end else if (fifo_pop) begin
                wleft <= wleft - 6'h01;
                wdrv  <= (wr_stop ? wdrv - (HALF - age) : wdrv) - ((wdrv != 6'h00) ? 6'h01 : 6'h00);
            end else if (wr_stop) begin
                wdrv  <= wdrv - (HALF - age);
            end
            // Words past a stop are drained with the pins released
            o_dq_oe  <= fifo_pop && wdrv != 6'h00;
            o_dqs_oe <= fifo_pop && wdrv != 6'h00;
            o_dqs    <= fifo_pop && wdrv != 6'h00;
            o_dq     <= fifo_out_data[`LSBP_DQ_W-1:0];
            o_dm     <= fifo_out_data[`LSBP_DQ_W+`LSBP_DM_W-1:`LSBP_DQ_W];
            fall_hold <= fifo_out_data[2*(`LSBP_DQ_W+`LSBP_DM_W)-1:`LSBP_DQ_W+`LSBP_DM_W];
        end
    end

endmodule // lsbp_ctrl

// Synchronous FIFO with registered input ready
module lsbp_fifo #(
    parameter W  = 36,
    parameter D  = 8,
    parameter CW = 4
) (
    input  wire          i_clk,
    input  wire          i_rst_n,
    input  wire          i_in_valid,
    input  wire [W-1:0]  i_in_data,
    output reg           o_in_ready,
    output wire          o_out_valid,
    output wire [W-1:0]  o_out_data,
    input  wire          i_out_ready,
    output reg  [CW-1:0] o_count
);
    reg  [W-1:0]  mem [0:D-1];
    reg  [CW-2:0] wp, rp;
    wire          push = i_in_valid && o_in_ready;
    wire          pop  = i_out_ready && o_out_valid;
    reg  [CW-1:0] next_count;

    assign o_out_valid = (o_count != {CW{1'b0}});
    assign o_out_data  = mem[rp];

    // Occupancy after this edge
    always @* begin
        next_count = o_count + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
    end

    // Pointers, count and registered ready
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp         <= {(CW-1){1'b0}};
            rp         <= {(CW-1){1'b0}};
            o_count    <= {CW{1'b0}};
            o_in_ready <= 1'b0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop)  rp <= rp + 1'b1;
            o_count    <= next_count;
            o_in_ready <= (next_count != D[CW-1:0]);
        end
    end

    // Storage
    always @(posedge i_clk) begin
        if (push) mem[wp] <= i_in_data;
    end
endmodule // lsbp_fifo

// ### tb/lsbp_ctrl_monitor.sv
// Checker for command framing, burst stop legality, precharge spacing and write strobes
`timescale 1ns/1ps
`include "lsbp_map.vh"
module lsbp_ctrl_monitor (
    input wire       i_mclk,
    input wire       i_resetn,
    input wire       o_cmd_ack,
    input wire       o_cmd_refused,
    input wire [7:0] o_bank_open,
    input wire       o_ck,
    input wire       o_cs_n,
    input wire [9:0] o_ca,
    input wire       o_dq_oe,
    input wire       o_dqs,
    input wire       o_dqs_oe
);
    // Decoded rise words as seen on the pins
    wire       rise_w = !o_cs_n && o_ck;
    wire       wr_w   = rise_w && o_ca[3:0] == `LSBP_CA_WRITE;
    wire       rw_w   = wr_w || (rise_w && o_ca[3:0] == `LSBP_CA_READ);
    wire       bst_w  = rise_w && o_ca[3:0] == `LSBP_CA_BST;
    wire       pre_w  = rise_w && o_ca[3:0] == `LSBP_CA_PRE;
    reg        acc_wr;
    reg  [2:0] acc_bank;
    reg  [2:0] pre_bank;
    reg  [3:0] pre_wait;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // Cycles left before a precharge may reach the last accessed bank
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_wr   <= 1'b0;
            acc_bank <= 3'h0;
            pre_bank <= 3'h0;
            pre_wait <= 4'h0;
        end else begin
            pre_bank <= pre_w ? o_ca[9:7] : pre_bank;
            if (rw_w) begin
                acc_wr   <= wr_w;
                acc_bank <= o_ca[9:7];
                pre_wait <= wr_w ? 4'hd : 4'h7;
            end else if (bst_w) begin
                pre_wait <= acc_wr ? 4'h5 : 4'h1;
            end else if (pre_wait != 4'h0) begin
                pre_wait <= pre_wait - 4'h1;
            end
        end
    end
    // One data word: strobe high with the rise beat, low with the fall beat
    sequence s_word;
        o_dq_oe && o_dqs && o_dqs_oe ##1 o_dq_oe && !o_dqs;
    endsequence
    a_cmd_two_halves: assert property (rise_w |=> !o_cs_n && !o_ck && !o_cmd_ack)
        else $error("command word not held for a device clock");
    a_ack_on_cmd: assert property (o_cmd_ack |-> rise_w)
        else $error("ack without a command on the pins");
    a_refuse_idle: assert property (o_cmd_refused |-> o_cs_n && !o_cmd_ack)
        else $error("refused command reached the pins");
    a_bst_even_age: assert property (bst_w |-> $past(rw_w, 4) && !$past(o_ca[0], 3))
        else $error("burst stop at a wrong age or on auto-precharge");
    a_pre_spacing: assert property (pre_w && (o_ca[4] || o_ca[9:7] == acc_bank)
        |-> pre_wait == 4'h0)
        else $error("precharge too soon after access");
    a_close_one: assert property (pre_w && !o_ca[4] |=> !o_bank_open[pre_bank])
        else $error("single bank not closed");
    a_close_all: assert property (pre_w && o_ca[4] |=> o_bank_open == 8'h00)
        else $error("banks not all closed");
    a_wr_first: assert property (wr_w |-> ##2 s_word)
        else $error("first write word misplaced");
    a_wr_whole: assert property (wr_w ##4 !bst_w |-> s_word ##1 s_word ##1 s_word)
        else $error("write burst cut short");
    a_wr_cut: assert property (wr_w ##4 bst_w |-> ##2 !o_dq_oe [*4])
        else $error("write data past burst stop");
endmodule // lsbp_ctrl_monitor

bind lsbp_ctrl lsbp_ctrl_monitor mon_u (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .o_cmd_ack(o_cmd_ack), .o_cmd_refused(o_cmd_refused), .o_bank_open(o_bank_open),
    .o_ck(o_ck), .o_cs_n(o_cs_n), .o_ca(o_ca), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
    .o_dqs_oe(o_dqs_oe));

// ### tb/lsbp_dev_model.sv
// Behavioural memory device decoding commands and capturing write beats
`timescale 1ns/1ps
`include "lsbp_map.vh"
module lsbp_dev_model (
    input wire        i_mclk,
    input wire        i_ck,
    input wire        i_cs_n,
    input wire [9:0]  i_ca,
    input wire [15:0] i_dq,
    input wire        i_dq_oe,
    input wire [1:0]  i_dm
);
    reg [7:0]  m_open = 8'h00;
    reg [3:0]  m_code = 4'h0;
    reg [2:0]  m_bank = 3'h0;
    reg [15:0] m_mem = 16'h0;
    reg [17:0] m_beats [$];
    // Rise word on the high half of the device clock, fall word on the low half
    always @(posedge i_mclk) begin
        if (!i_cs_n && i_ck) begin
            m_code <= i_ca[3:0];
            m_bank <= i_ca[9:7];
            if (i_ca[3:0] == `LSBP_CA_ACT)
                m_open[i_ca[9:7]] <= 1'b1;
            if (i_ca[3:0] == `LSBP_CA_PRE)
                m_open <= i_ca[`LSBP_CA_AB_BIT] ? 8'h00 : m_open & ~(8'h01 << i_ca[9:7]);
        end else if (!i_cs_n && (m_code == `LSBP_CA_READ || m_code == `LSBP_CA_WRITE)) begin
            if (i_ca[`LSBP_CA_AP_BIT])
                m_open[m_bank] <= 1'b0;
        end
        // Each beat lands with its mask; blocked lanes keep old bytes
        if (i_dq_oe) begin
            m_beats.push_back({i_dm, i_dq});
            m_mem <= {i_dm[1] ? m_mem[15:8] : i_dq[15:8], i_dm[0] ? m_mem[7:0] : i_dq[7:0]};
        end
    end
endmodule // lsbp_dev_model

// ### tb/test_lsbp_ctrl.sv
// Self-checking bench for the burst stop and precharge controller
`timescale 1ns/1ps
`include "lsbp_map.vh"
module test_lsbp_ctrl;
    reg         i_mclk = 1'b0;
    reg         i_resetn = 1'b0;
    reg         i_cmd_valid = 1'b0;
    reg  [2:0]  i_cmd_op = 3'h0;
    reg  [2:0]  i_cmd_bank = 3'h0;
    reg  [12:0] i_cmd_addr = 13'h0;
    reg         i_cmd_ap = 1'b0;
    reg         i_wdata_valid = 1'b0;
    reg  [31:0] i_wdata = 32'h0;
    reg  [3:0]  i_wmask = 4'h0;
    wire        o_wdata_ready, o_cmd_ack, o_cmd_refused, o_ck, o_cs_n, o_dq_oe, o_dqs, o_dqs_oe;
    wire [7:0]  o_bank_open;
    wire [9:0]  o_ca;
    wire [15:0] o_dq;
    wire [1:0]  o_dm;
    reg  [31:0] lfsr = 32'hee19e9da;
    reg  [7:0]  exp_open = 8'h00;
    reg  [15:0] exp_mem = 16'h0;
    reg  [35:0] words [$];
    integer     n_mismatch = 0;
    integer     check_count = 0;
    integer     i, k;
    // Clock at 40 MHz
    always #12.5 i_mclk = ~i_mclk;
    lsbp_ctrl dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
        .i_cmd_op(i_cmd_op), .i_cmd_bank(i_cmd_bank), .i_cmd_addr(i_cmd_addr),
        .i_cmd_ap(i_cmd_ap), .i_wdata_valid(i_wdata_valid), .i_wdata(i_wdata),
        .i_wmask(i_wmask), .o_wdata_ready(o_wdata_ready), .o_cmd_ack(o_cmd_ack),
        .o_cmd_refused(o_cmd_refused), .o_bank_open(o_bank_open), .o_ck(o_ck),
        .o_cs_n(o_cs_n), .o_ca(o_ca), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dm(o_dm),
        .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe));
    lsbp_dev_model dev_u (.i_mclk(i_mclk), .i_ck(o_ck), .i_cs_n(o_cs_n), .i_ca(o_ca),
        .i_dq(o_dq), .i_dq_oe(o_dq_oe), .i_dm(o_dm));
    function [31:0] step(input [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] next_open(input [7:0] o, input [2:0] op, input [2:0] b, input ap);
        case (op)
            3'h0: next_open = o | (8'h01 << b);
            3'h4: next_open = o & ~(8'h01 << b);
            3'h5: next_open = 8'h00;
            default: next_open = ap ? o & ~(8'h01 << b) : o;
        endcase
    endfunction
    task check(input [63:0] seen, input [63:0] exp, input string what);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // One command held until answered, then the bank flags compared
    task cmd(input [2:0] op, input [2:0] b, input ap, input refuse);
        integer t;
        begin
            {i_cmd_op, i_cmd_bank, i_cmd_ap, i_cmd_addr} = {op, b, ap, lfsr[12:0]};
            lfsr = step(lfsr);
            i_cmd_valid = 1'b1;
            for (t = 0; t < 200 && o_cmd_ack !== 1'b1 && o_cmd_refused !== 1'b1; t = t + 1)
                tick(1);
            i_cmd_valid = 1'b0;
            check({63'h0, t == 200}, 64'h0, "answer timeout");
            if (t == 200) tally_and_finish;
            check({63'h0, o_cmd_refused}, {63'h0, refuse}, "refused");
            if (!refuse)
                exp_open = next_open(exp_open, op, b, ap);
            tick(1);
            check(o_bank_open, exp_open, "bank open");
        end
    endtask
    // Random words into the buffer; with stop set, until it refuses
    task push(input integer n, input stop);
        integer t;
        begin
            k = 0;
            for (t = 0; k < n && t < 200 && !(stop && o_wdata_ready !== 1'b1); t = t + 1) begin
                i_wdata_valid = o_wdata_ready;
                if (o_wdata_ready === 1'b1) begin
                    {i_wmask, i_wdata} = {lfsr[3:0], step(lfsr)};
                    words.push_back({i_wmask, i_wdata});
                    lfsr = step(step(lfsr));
                    k = k + 1;
                end
                tick(1);
            end
            i_wdata_valid = 1'b0;
            check({63'h0, t == 200}, 64'h0, "push timeout");
            if (t == 200) tally_and_finish;
        end
    endtask
    // Beats seen by the device against the pushed words
    task beats(input integer nw);
        reg [35:0] w;
        begin
            check(dev_u.m_beats.size(), 2 * nw, "beat count");
            for (i = 0; i < nw && dev_u.m_beats.size() > 1; i = i + 1) begin
                w = words.pop_front();
                check(dev_u.m_beats.pop_front(), {w[33:32], w[15:0]}, "rise beat");
                check(dev_u.m_beats.pop_front(), {w[35:34], w[31:16]}, "fall beat");
                exp_mem = {w[33] ? exp_mem[15:8] : w[15:8], w[32] ? exp_mem[7:0] : w[7:0]};
                exp_mem = {w[35] ? exp_mem[15:8] : w[31:24], w[34] ? exp_mem[7:0] : w[23:16]};
            end
            check(dev_u.m_mem, exp_mem, "masked store");
            dev_u.m_beats.delete();
            words.delete();
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge i_mclk);
        check(64'h1, 64'h0, "run timeout");
        tally_and_finish;
    end
    // Main sequence
    initial begin
        tick(3);
        i_resetn = 1'b1;
        tick(3);
        for (i = 0; i < 8; i = i + 1)
            cmd(3'h0, i[2:0], 1'b0, 1'b0);
        cmd(3'h4, lfsr[2:0], 1'b0, 1'b0);
        cmd(3'h5, 3'h0, 1'b0, 1'b0);
        cmd(3'h3, 3'h0, 1'b0, 1'b1);
        cmd(3'h6, 3'h0, 1'b0, 1'b1);
        cmd(3'h0, 3'h0, 1'b0, 1'b0);
        push(4, 1'b0);
        cmd(3'h2, 3'h0, 1'b0, 1'b0);
        tick(12);
        beats(4);
        push(4, 1'b0);
        cmd(3'h2, 3'h0, 1'b0, 1'b0);
        cmd(3'h3, 3'h0, 1'b0, 1'b1);
        cmd(3'h3, 3'h0, 1'b0, 1'b0);
        cmd(3'h3, 3'h0, 1'b0, 1'b1);
        tick(12);
        beats(2);
        cmd(3'h4, 3'h0, 1'b0, 1'b0);
        cmd(3'h0, 3'h1, 1'b0, 1'b0);
        cmd(3'h1, 3'h1, 1'b0, 1'b0);
        tick(1);
        cmd(3'h3, 3'h1, 1'b0, 1'b0);
        cmd(3'h4, 3'h1, 1'b0, 1'b0);
        cmd(3'h0, 3'h2, 1'b0, 1'b0);
        cmd(3'h1, 3'h2, 1'b1, 1'b0);
        tick(1);
        cmd(3'h3, 3'h2, 1'b0, 1'b1);
        push(12, 1'b1);
        check(k, `LSBP_FIFO_DEPTH, "fifo fill");
        cmd(3'h0, 3'h3, 1'b0, 1'b0);
        cmd(3'h2, 3'h3, 1'b1, 1'b0);
        cmd(3'h0, 3'h3, 1'b0, 1'b0);
        cmd(3'h2, 3'h3, 1'b0, 1'b0);
        tick(12);
        beats(8);
        check({63'h0, o_wdata_ready}, 64'h1, "fifo ready");
        for (i = 0; i < 24; i = i + 1) begin
            lfsr = step(lfsr);
            if (exp_open[lfsr[2:0]] !== 1'b1)
                cmd(3'h0, lfsr[2:0], 1'b0, 1'b0);
            else if (lfsr[3])
                cmd(3'h1, lfsr[2:0], lfsr[4], 1'b0);
            else
                cmd({2'h2, lfsr[5]}, lfsr[2:0], 1'b0, 1'b0);
            tick(2);
            check(dev_u.m_open, exp_open, "model banks");
        end
        tally_and_finish;
    end
endmodule // test_lsbp_ctrl
